// file: rspc_defines.svh
// offsets, field positions, reset values and timing counts of the reset and power control block
`ifndef RSPC_DEFINES_SVH
`define RSPC_DEFINES_SVH

`define RSPC_SLAVE_ADDR 7'h18

`define RSPC_PAGE0 8'h00
`define RSPC_PAGE1 8'h01

`define RSPC_REG_PAGE 8'h00
`define RSPC_REG_SOFT_RESET 8'h01
`define RSPC_REG_PLL_POWER 8'h05
`define RSPC_REG_DAC_POWER 8'h3f
`define RSPC_REG_HP_STAGE_RST 8'h1f
`define RSPC_REG_SPK_STAGE_RST 8'h20
`define RSPC_REG_STAGE_POWER 8'h21
`define RSPC_REG_STATUS 8'h22

`define RSPC_SOFT_RESET_BIT 0
`define RSPC_PLL_POWER_BIT 7
`define RSPC_LEFT_BIT 7
`define RSPC_RIGHT_BIT 6

`define RSPC_REG_RESET 8'h00

`define RSPC_CLOCK_MHZ 125
`define RSPC_INIT_TIME_US 1000
`define RSPC_PLL_TIME_US 10000
`define RSPC_INIT_CYCLES (`RSPC_INIT_TIME_US * `RSPC_CLOCK_MHZ)
`define RSPC_PLL_CYCLES (`RSPC_PLL_TIME_US * `RSPC_CLOCK_MHZ)

`endif

// file: rspc_host_model.sv
// serial control host model that drives the two-wire bus as master
`timescale 1ns/10ps
module rspc_host_model (
   input wire logic i_clock,
   input wire logic i_sda_oe_n,
   output logic o_scl,
   output logic o_sda
);
   logic low_q = 1'b0;
   // pull-up wins unless a party pulls the line low
   assign o_sda = ~low_q & i_sda_oe_n;
   initial o_scl = 1'b1;
   task wt(input int n);
      repeat (n) @(posedge i_clock);
   endtask
   // 12 clocks a phase covers the slave's pin sync lag
   task bt(input logic b, output logic r);
      low_q <= ~b;
      wt(12);
      o_scl <= 1'b1;
      wt(12);
      r = o_sda;
      o_scl <= 1'b0;
      wt(1);
   endtask
   task sta;
      low_q <= 1'b0;
      wt(12);
      o_scl <= 1'b1;
      wt(12);
      low_q <= 1'b1;
      wt(12);
      o_scl <= 1'b0;
      wt(12);
   endtask
   task sto;
      low_q <= 1'b1;
      wt(12);
      o_scl <= 1'b1;
      wt(12);
      low_q <= 1'b0;
      wt(12);
   endtask
   task byt(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bt(d[i], r[i]);
      bt(mack, a);
      ack = ~a;
   endtask
   task wr(input logic [7:0] off, input logic [7:0] d0, input logic [7:0] d1, input logic two,
           output logic ok);
      logic [7:0] r;
      logic a0, a1, a2, a3;
      a3 = 1'b1;
      sta;
      byt(8'h30, 1'b1, r, a0);
      byt(off, 1'b1, r, a1);
      byt(d0, 1'b1, r, a2);
      if (two) byt(d1, 1'b1, r, a3);
      sto;
      ok = a0 & a1 & a2 & a3;
   endtask
   task rd(input logic [7:0] off, output logic [7:0] d);
      logic [7:0] r;
      logic a;
      sta;
      byt(8'h30, 1'b1, r, a);
      byt(off, 1'b1, r, a);
      sta;
      byt(8'h31, 1'b1, r, a);
      byt(8'hff, 1'b1, d, a);
      sto;
   endtask
   task probe(input logic [6:0] adr, output logic ok);
      logic [7:0] r;
      sta;
      byt({adr, 1'b0}, 1'b1, r, ok);
      sto;
   endtask
endmodule

// file: rspc_i2c_slave.sv
// two-wire serial control slave with register pointer auto-increment
`timescale 1ns/10ps
`include "rspc_defines.svh"
module rspc_i2c_slave #(
   parameter logic [6:0] SLAVE_ADDR = `RSPC_SLAVE_ADDR
) (
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   rspc_regbus_if.initiator bus
);
   logic [2:0] scl_q;
   logic [2:0] sda_q;
   rspc_pkg::rspc_state_e state_q;
   logic [3:0] cnt_q;
   logic [7:0] shift_q;
   logic [7:0] ptr_q;
   logic rw_q;
   logic first_q;
   logic nack_q;
   logic wr_q;
   logic [7:0] waddr_q;
   logic [7:0] wdata_q;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   // open drain: only ever pulls low; the clock line is never driven
   assign o_sda_out = 1'b0;
   assign bus.wr = wr_q;
   assign bus.waddr = waddr_q;
   assign bus.wdata = wdata_q;
   assign bus.raddr = ptr_q;

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end else begin
         scl_q <= {scl_q[1:0], i_scl};
         sda_q <= {sda_q[1:0], i_sda};
      end
   end

   assign scl_rise = scl_q[1] && !scl_q[2];
   assign scl_fall = !scl_q[1] && scl_q[2];
   assign start_det = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1];
   assign stop_det = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1];

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q <= rspc_pkg::RSPC_IDLE;
         cnt_q <= 4'h0;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         first_q <= 1'b0;
         nack_q <= 1'b1;
         wr_q <= 1'b0;
         waddr_q <= 8'h00;
         wdata_q <= 8'h00;
         o_sda_oe_n <= 1'b1;
      end else begin
         wr_q <= 1'b0;
         if (start_det) begin
            state_q <= rspc_pkg::RSPC_ADDR;
            cnt_q <= 4'h0;
            o_sda_oe_n <= 1'b1;
         end else if (stop_det) begin
            state_q <= rspc_pkg::RSPC_IDLE;
            o_sda_oe_n <= 1'b1;
         end else if (scl_rise) begin
            case (state_q)
               rspc_pkg::RSPC_ADDR, rspc_pkg::RSPC_WDATA: begin
                  shift_q <= {shift_q[6:0], sda_q[1]};
                  cnt_q <= cnt_q + 4'h1;
               end
               rspc_pkg::RSPC_RDATA: cnt_q <= cnt_q + 4'h1;
               rspc_pkg::RSPC_RACK: nack_q <= sda_q[1];
               default: ;
            endcase
         end else if (scl_fall) begin
            case (state_q)
               rspc_pkg::RSPC_ADDR: begin
                  if (cnt_q == 4'h8) begin
                     cnt_q <= 4'h0;
                     if (shift_q[7:1] == SLAVE_ADDR) begin
                        rw_q <= shift_q[0];
                        state_q <= rspc_pkg::RSPC_AACK;
                        o_sda_oe_n <= 1'b0;
                     end else begin
                        state_q <= rspc_pkg::RSPC_IDLE;
                     end
                  end
               end
               rspc_pkg::RSPC_AACK: begin
                  if (rw_q) begin
                     shift_q <= bus.rdata;
                     o_sda_oe_n <= bus.rdata[7];
                     state_q <= rspc_pkg::RSPC_RDATA;
                  end else begin
                     o_sda_oe_n <= 1'b1;
                     first_q <= 1'b1;
                     state_q <= rspc_pkg::RSPC_WDATA;
                  end
               end
               rspc_pkg::RSPC_WDATA: begin
                  if (cnt_q == 4'h8) begin
                     cnt_q <= 4'h0;
                     o_sda_oe_n <= 1'b0;
                     state_q <= rspc_pkg::RSPC_WACK;
                     if (first_q) begin
                        ptr_q <= shift_q;
                        first_q <= 1'b0;
                     end else begin
                        wr_q <= 1'b1;
                        waddr_q <= ptr_q;
                        wdata_q <= shift_q;
                        ptr_q <= ptr_q + 8'h01;
                     end
                  end
               end
               rspc_pkg::RSPC_WACK: begin
                  o_sda_oe_n <= 1'b1;
                  state_q <= rspc_pkg::RSPC_WDATA;
               end
               rspc_pkg::RSPC_RDATA: begin
                  if (cnt_q == 4'h8) begin
                     cnt_q <= 4'h0;
                     o_sda_oe_n <= 1'b1;
                     ptr_q <= ptr_q + 8'h01;
                     state_q <= rspc_pkg::RSPC_RACK;
                  end else begin
                     o_sda_oe_n <= shift_q[3'h7 - cnt_q[2:0]];
                  end
               end
               rspc_pkg::RSPC_RACK: begin
                  if (!nack_q) begin
                     shift_q <= bus.rdata;
                     o_sda_oe_n <= bus.rdata[7];
                     state_q <= rspc_pkg::RSPC_RDATA;
                  end else begin
                     state_q <= rspc_pkg::RSPC_IDLE;
                  end
               end
               default: state_q <= rspc_pkg::RSPC_IDLE;
            endcase
         end
      end
   end

   AST_FOREIGN_ADDR_IGNORED: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      state_q == rspc_pkg::RSPC_ADDR && scl_fall && cnt_q == 4'h8 && shift_q[7:1] != SLAVE_ADDR
      |=> state_q == rspc_pkg::RSPC_IDLE && o_sda_oe_n)
      else $error("foreign address was not ignored");
   AST_OWN_ADDR_ACKED: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      state_q == rspc_pkg::RSPC_ADDR && scl_fall && cnt_q == 4'h8 && shift_q[7:1] == SLAVE_ADDR
      |=> state_q == rspc_pkg::RSPC_AACK && !o_sda_oe_n)
      else $error("own address not acknowledged");
   AST_DRIVES_ONLY_AS_SLAVE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      !o_sda_oe_n |-> state_q inside {rspc_pkg::RSPC_AACK, rspc_pkg::RSPC_WACK, rspc_pkg::RSPC_RDATA})
      else $error("data line driven outside a slave phase");
   AST_POINTER_STEPS: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      wr_q |-> ptr_q == waddr_q + 8'h01 && wdata_q == $past(shift_q) ##1 !wr_q)
      else $error("pointer did not step after a data byte");
endmodule

// file: rspc_pkg.sv
// types shared by the reset and power control block
package rspc_pkg;
   typedef enum logic [2:0] {
      RSPC_IDLE = 3'h0,
      RSPC_ADDR = 3'h1,
      RSPC_AACK = 3'h3,
      RSPC_WDATA = 3'h2,
      RSPC_WACK = 3'h6,
      RSPC_RDATA = 3'h7,
      RSPC_RACK = 3'h5
   } rspc_state_e;
endpackage

// file: rspc_regbus_if.sv
// register access carrier between the serial slave and the register file
`timescale 1ns/10ps
interface rspc_regbus_if;
   logic wr;
   logic [7:0] waddr;
   logic [7:0] wdata;
   logic [7:0] raddr;
   logic [7:0] rdata;
   modport initiator (output wr, output waddr, output wdata, output raddr, input rdata);
   modport target (input wr, input waddr, input wdata, input raddr, output rdata);
endinterface

// file: rspc_timer.sv
// restartable delay counter, done after CYCLES clocks with clear low
`timescale 1ns/10ps
`include "rspc_defines.svh"
module rspc_timer #(
   parameter int unsigned CYCLES = 1
) (
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire logic i_clear,
   output logic o_done
);
   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);
   logic [W-1:0] cnt_q;

   generate
      if (CYCLES < 1) begin : g_bad
         $error("rspc_timer needs at least one cycle");
      end
   endgenerate

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_q <= '0;
         o_done <= 1'b0;
      end else if (i_clear) begin
         cnt_q <= '0;
         o_done <= 1'b0;
      end else if (!o_done) begin
         if (cnt_q == LAST) begin
            o_done <= 1'b1;
         end else begin
            cnt_q <= cnt_q + W'(1);
         end
      end
   end
endmodule

// file: rspc_top.sv
// reset, start-up lockout and power control with its serial register port
//
// Behaviour
// - answer only slave address 0011000
// - slave only, never drive the clock
// - eight-bit registers, written values read back
// - pointer steps per data byte, fast mode
// - soft reset bit equals hardware reset
// - memory initialisation done within 1 ms
// - clocks withheld 10 ms after PLL power-up
// - headphone stage reset bits, left and right
// - speaker stage reset bits, left and right
// - stage reset clears only its shutdown
// - all blocks powered down after reset
// - power-down keeps every register setting
`timescale 1ns/10ps
`include "rspc_defines.svh"
module rspc_top #(
   parameter int unsigned INIT_CYCLES = `RSPC_INIT_CYCLES,
   parameter int unsigned PLL_CYCLES = `RSPC_PLL_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_arst_n,
   input wire logic i_reset_pin_n,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   input wire logic [3:0] i_overcurrent,
   output logic o_pll_power,
   output logic o_clocks_enable,
   output logic o_dac_left_power,
   output logic o_dac_right_power,
   output logic [3:0] o_stage_enable,
   output logic [3:0] o_stage_shutdown,
   output logic o_init_busy
);
   localparam int STAGES = 4;

   rspc_regbus_if bus ();

   logic pin_seen_q;
   logic pin_s1_q;
   logic pin_s2_q;
   logic soft_rst_q;
   logic logic_rst;
   logic [7:0] page_q;
   logic pll_power_q;
   logic [1:0] dac_power_q;
   logic [3:0] stage_power_q;
   logic [5:0] hp_misc_q;
   logic [5:0] spk_misc_q;
   logic [3:0] stage_rst_q;
   logic init_done;
   logic pll_done;
   logic init_busy_q;
   logic clocks_en_q;
   logic [7:0] rdata;
   logic wr_p0;
   logic wr_p1;
   wire [3:0] stage_en_w;
   wire [3:0] shut_w;

   generate
      if (PLL_CYCLES < 2 || INIT_CYCLES < 2) begin : g_bad
         $error("rspc_top delay counts must be at least two cycles");
      end
   endgenerate

   rspc_i2c_slave #(
      .SLAVE_ADDR(`RSPC_SLAVE_ADDR)
   ) u_slave (
      .i_clock(i_clock),
      .i_arst_n(i_arst_n),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .o_sda_out(o_sda_out),
      .o_sda_oe_n(o_sda_oe_n),
      .bus(bus.initiator)
   );

   // a 10 ns pulse is shorter than two clocks, so catch it asynchronously first
   always_ff @(posedge i_clock or negedge i_reset_pin_n) begin
      if (!i_reset_pin_n) begin
         pin_seen_q <= 1'b0;
      end else begin
         pin_seen_q <= 1'b1;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
      end else begin
         pin_s1_q <= pin_seen_q;
         pin_s2_q <= pin_s1_q;
      end
   end

   // pin reset and software reset take the same path to defaults
   assign logic_rst = soft_rst_q || !pin_s2_q;
   assign wr_p0 = bus.wr && page_q == `RSPC_PAGE0;
   assign wr_p1 = bus.wr && page_q == `RSPC_PAGE1;

   // one-cycle pulse, so the bit reads back zero afterwards
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= wr_p0 && bus.waddr == `RSPC_REG_SOFT_RESET
            && bus.wdata[`RSPC_SOFT_RESET_BIT];
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         page_q <= `RSPC_REG_RESET;
      end else if (logic_rst) begin
         page_q <= `RSPC_REG_RESET;
      end else if (bus.wr && bus.waddr == `RSPC_REG_PAGE) begin
         page_q <= bus.wdata;
      end
   end

   // power bits default to off and change only on their own register
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pll_power_q <= 1'b0;
         dac_power_q <= 2'h0;
         stage_power_q <= 4'h0;
      end else if (logic_rst) begin
         pll_power_q <= 1'b0;
         dac_power_q <= 2'h0;
         stage_power_q <= 4'h0;
      end else if (wr_p0 && bus.waddr == `RSPC_REG_PLL_POWER) begin
         pll_power_q <= bus.wdata[`RSPC_PLL_POWER_BIT];
      end else if (wr_p0 && bus.waddr == `RSPC_REG_DAC_POWER) begin
         dac_power_q <= {bus.wdata[`RSPC_LEFT_BIT], bus.wdata[`RSPC_RIGHT_BIT]};
      end else if (wr_p1 && bus.waddr == `RSPC_REG_STAGE_POWER) begin
         stage_power_q <= bus.wdata[7:4];
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hp_misc_q <= 6'h00;
         spk_misc_q <= 6'h00;
      end else if (logic_rst) begin
         hp_misc_q <= 6'h00;
         spk_misc_q <= 6'h00;
      end else if (wr_p1 && bus.waddr == `RSPC_REG_HP_STAGE_RST) begin
         hp_misc_q <= bus.wdata[5:0];
      end else if (wr_p1 && bus.waddr == `RSPC_REG_SPK_STAGE_RST) begin
         spk_misc_q <= bus.wdata[5:0];
      end
   end

   // stage order: left headphone, right headphone, left speaker pair, right speaker pair
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         stage_rst_q <= 4'h0;
      end else begin
         stage_rst_q <= 4'h0;
         if (wr_p1 && bus.waddr == `RSPC_REG_HP_STAGE_RST) begin
            stage_rst_q[1:0] <= {bus.wdata[`RSPC_RIGHT_BIT], bus.wdata[`RSPC_LEFT_BIT]};
         end
         if (wr_p1 && bus.waddr == `RSPC_REG_SPK_STAGE_RST) begin
            stage_rst_q[3:2] <= {bus.wdata[`RSPC_RIGHT_BIT], bus.wdata[`RSPC_LEFT_BIT]};
         end
      end
   end

   rspc_timer #(
      .CYCLES(INIT_CYCLES)
   ) u_init_timer (
      .i_clock(i_clock),
      .i_arst_n(i_arst_n),
      .i_clear(logic_rst),
      .o_done(init_done)
   );

   // the host is trusted to keep blocks off while this reads busy
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         init_busy_q <= 1'b1;
      end else begin
         init_busy_q <= !init_done;
      end
   end

   rspc_timer #(
      .CYCLES(PLL_CYCLES)
   ) u_pll_timer (
      .i_clock(i_clock),
      .i_arst_n(i_arst_n),
      .i_clear(!pll_power_q),
      .o_done(pll_done)
   );

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         clocks_en_q <= 1'b0;
      end else begin
         clocks_en_q <= pll_done && pll_power_q;
      end
   end

   generate
      for (genvar g = 0; g < STAGES; g++) begin : g_stage
         logic oc_s1_q;
         logic oc_s2_q;
         logic shut_q;
         logic en_q;

         always_ff @(posedge i_clock or negedge i_arst_n) begin
            if (!i_arst_n) begin
               oc_s1_q <= 1'b0;
               oc_s2_q <= 1'b0;
            end else begin
               oc_s1_q <= i_overcurrent[g];
               oc_s2_q <= oc_s1_q;
            end
         end

         // a new overcurrent outranks a reset request in the same cycle
         always_ff @(posedge i_clock or negedge i_arst_n) begin
            if (!i_arst_n) begin
               shut_q <= 1'b0;
            end else if (oc_s2_q && en_q) begin
               shut_q <= 1'b1;
            end else if (stage_rst_q[g] || logic_rst) begin
               shut_q <= 1'b0;
            end
         end

         always_ff @(posedge i_clock or negedge i_arst_n) begin
            if (!i_arst_n) begin
               en_q <= 1'b0;
            end else begin
               en_q <= stage_power_q[STAGES-1-g] && !shut_q && !(oc_s2_q && en_q);
            end
         end

         assign stage_en_w[g] = en_q;
         assign shut_w[g] = shut_q;

         AST_STAGE_RESET_CLEARS: assert property (@(posedge i_clock) disable iff (!i_arst_n)
            stage_rst_q[g] && !(oc_s2_q && en_q) |=> !shut_q)
            else $error("stage reset left shutdown latched");
      end
   endgenerate

   always_comb begin
      rdata = 8'h00;
      if (bus.raddr == `RSPC_REG_PAGE) begin
         rdata = page_q;
      end else if (page_q == `RSPC_PAGE0) begin
         case (bus.raddr)
            `RSPC_REG_PLL_POWER: rdata = {pll_power_q, 7'h00};
            `RSPC_REG_DAC_POWER: rdata = {dac_power_q, 6'h00};
            default: rdata = 8'h00;
         endcase
      end else if (page_q == `RSPC_PAGE1) begin
         case (bus.raddr)
            `RSPC_REG_HP_STAGE_RST: rdata = {2'h0, hp_misc_q};
            `RSPC_REG_SPK_STAGE_RST: rdata = {2'h0, spk_misc_q};
            `RSPC_REG_STAGE_POWER: rdata = {stage_power_q, 4'h0};
            `RSPC_REG_STATUS: rdata = {shut_w, 2'h0, clocks_en_q, init_busy_q};
            default: rdata = 8'h00;
         endcase
      end
   end

   assign bus.rdata = rdata;
   assign o_pll_power = pll_power_q;
   assign o_clocks_enable = clocks_en_q;
   assign o_dac_left_power = dac_power_q[1];
   assign o_dac_right_power = dac_power_q[0];
   assign o_stage_enable = stage_en_w;
   assign o_stage_shutdown = shut_w;
   assign o_init_busy = init_busy_q;

   // cycles the PLL has been powered with clocks still held back
   int unsigned pll_wait_q;
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pll_wait_q <= 0;
      end else if (!pll_power_q) begin
         pll_wait_q <= 0;
      end else if (!clocks_en_q) begin
         pll_wait_q <= pll_wait_q + 1;
      end
   end

   AST_SOFT_RESET_PULSE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      wr_p0 && bus.waddr == `RSPC_REG_SOFT_RESET && bus.wdata[`RSPC_SOFT_RESET_BIT]
      |=> soft_rst_q ##1 !soft_rst_q && page_q == 8'h00 && hp_misc_q == 6'h00)
      else $error("soft reset did not act once and restore defaults");
   AST_POWERED_DOWN_AFTER_RESET: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      logic_rst |=> !pll_power_q && dac_power_q == 2'h0 && stage_power_q == 4'h0 ##1 o_stage_enable == 4'h0)
      else $error("a block stayed powered after reset");
   AST_INIT_LOCKOUT: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      logic_rst |-> ##2 o_init_busy)
      else $error("initialisation busy not raised after reset");
   AST_PLL_SETTLE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      $rose(clocks_en_q) |-> pll_wait_q >= PLL_CYCLES && pll_wait_q <= PLL_CYCLES + 2)
      else $error("clocks released off the settling delay");
   AST_STAGE_RESET_LOCAL: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      stage_rst_q != 4'h0 && !logic_rst |-> $stable(stage_power_q) && $stable(pll_power_q) && $stable(page_q))
      else $error("stage reset disturbed other registers");
   AST_READ_BACK: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      wr_p1 && bus.waddr == `RSPC_REG_STAGE_POWER && !logic_rst |=> stage_power_q == $past(bus.wdata[7:4]))
      else $error("written power value not held for read back");
   AST_POWER_DOWN_RETAINS: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      $fell(pll_power_q) && !$past(logic_rst) |-> $stable(dac_power_q) && $stable(hp_misc_q) && $stable(spk_misc_q))
      else $error("powering down changed a setting");
endmodule

// file: tb_top.sv
// self-checking bench for the reset and power control block
`timescale 1ns/10ps
module tb_top;
   logic clk = 1'b0, arst_n = 1'b0, pin_n = 1'b1, ok, sda, scl, sda_out, oe_n;
   logic pll, cen, dl, dr, busy;
   logic [3:0] oc = 4'h0, en, sd;
   logic [7:0] v;
   int fail_count = 0, n_tests = 0, n;
   always #4 clk = ~clk;
   rspc_top #(.INIT_CYCLES(20), .PLL_CYCLES(300)) dut (.i_clock(clk), .i_arst_n(arst_n),
      .i_reset_pin_n(pin_n), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe_n(oe_n),
      .i_overcurrent(oc), .o_pll_power(pll), .o_clocks_enable(cen), .o_dac_left_power(dl),
      .o_dac_right_power(dr), .o_stage_enable(en), .o_stage_shutdown(sd), .o_init_busy(busy));
   rspc_host_model host (.i_clock(clk), .i_sda_oe_n(oe_n), .o_scl(scl), .o_sda(sda));
   task chk(input logic [7:0] g, input logic [7:0] e, input string m);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task summarize;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // host stays off the bus while memories initialise
   task wait_idle;
      for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge clk);
      chk(busy, 8'h00, "init end");
   endtask
   task t_reset;
      chk({pll, cen, dl, dr, en}, 8'h00, "powered down");
      chk({sd, 3'h0, busy}, 8'h01, "init busy");
      wait_idle;
      $display("test reset done");
   endtask
   task t_addr;
      host.probe(7'h19, ok);
      chk(ok, 8'h00, "foreign addr");
      host.probe(7'h18, ok);
      chk(ok, 8'h01, "own addr");
      chk(sda_out, 8'h00, "data pin only pulled low");
      $display("test address done");
   endtask
   task t_power;
      host.wr(8'h3f, 8'hc0, 8'h00, 1'b0, ok);
      chk({ok, dl, dr}, 8'h07, "dac on");
      host.rd(8'h3f, v);
      chk(v, 8'hc0, "dac readback");
      host.wr(8'h05, 8'h80, 8'h00, 1'b0, ok);
      chk({pll, cen}, 8'h02, "pll settling");
      for (n = 0; n < 400 && cen !== 1'b1; n++) @(posedge clk);
      chk({cen, n < 200}, 8'h02, "clocks late");
      host.wr(8'h3f, 8'h00, 8'h00, 1'b0, ok);
      host.rd(8'h05, v);
      chk(v, 8'h80, "settings kept");
      chk({dl, dr}, 8'h00, "dac off");
      host.wr(8'h05, 8'h00, 8'h00, 1'b0, ok);
      chk({pll, cen}, 8'h00, "pll off");
      $display("test power done");
   endtask
   task t_stage;
      logic [3:0] m;
      host.wr(8'h00, 8'h01, 8'h00, 1'b0, ok);
      host.wr(8'h21, 8'hf0, 8'h00, 1'b0, ok);
      chk(en, 8'h0f, "stages on");
      for (int i = 0; i < 4; i++) begin
         m = 4'h1 << i;
         oc <= m;
         repeat (6) @(posedge clk);
         chk({en, sd}, {~m, m}, "shutdown");
         oc <= 4'h0;
         if (i == 0) begin
            host.rd(8'h22, v);
            chk(v, 8'h10, "status shows shutdown");
         end
         host.wr(i < 2 ? 8'h1f : 8'h20, i[0] ? 8'h40 : 8'h80, 8'h00, 1'b0, ok);
         chk({en, sd}, 8'hf0, "stage reset");
      end
      host.wr(8'h1f, 8'h15, 8'h2a, 1'b1, ok);
      host.rd(8'h20, v);
      chk(v, 8'h2a, "auto increment");
      host.rd(8'h1f, v);
      chk(v, 8'h15, "low bits");
      host.rd(8'h21, v);
      chk(v, 8'hf0, "others kept");
      $display("test stage done");
   endtask
   task t_soft;
      host.wr(8'h00, 8'h00, 8'h00, 1'b0, ok);
      host.wr(8'h05, 8'h80, 8'h00, 1'b0, ok);
      host.wr(8'h3f, 8'hc0, 8'h00, 1'b0, ok);
      chk({pll, dl, dr}, 8'h07, "on before soft reset");
      host.wr(8'h01, 8'h01, 8'h00, 1'b0, ok);
      chk({pll, cen, dl, dr, en}, 8'h00, "soft defaults");
      wait_idle;
      host.rd(8'h01, v);
      chk(v, 8'h00, "self clear");
      host.rd(8'h3f, v);
      chk(v, 8'h00, "regs default");
      $display("test soft reset done");
   endtask
   task t_pin;
      host.wr(8'h3f, 8'hc0, 8'h00, 1'b0, ok);
      pin_n <= 1'b0;
      repeat (2) @(posedge clk);
      pin_n <= 1'b1;
      repeat (5) @(posedge clk);
      chk({dl, dr, busy}, 8'h01, "pin reset");
      wait_idle;
      $display("test pin reset done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_reset;
      t_addr;
      t_power;
      t_stage;
      t_soft;
      t_pin;
      summarize;
   end
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      summarize;
   end
endmodule
